/* File: verilog/rxes_pkg.sv */
/*
 Constants of the receive error status bank: register indices, bit
 positions, reset values, bus answers and state codes.
 Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
*/
package rxes_pkg;
   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int LANES = 4;
   localparam int FLAG_W = 12;

   // ==========================================================
   // Register map: printed word indices, byte address is 4x
   localparam logic [ADDR_W-1:0] IDX_FLAGS = 12'h0d0;
   localparam logic [ADDR_W-1:0] IDX_ENABLE = 12'h0d1;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS[9:0], 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE[9:0], 2'h0};

   // ==========================================================
   // Flag positions
   localparam int BIT_DESKEW = 10;
   localparam int BIT_ECC_FATAL = 9;
   localparam int BIT_ECC_CORR = 8;
   localparam int BIT_ALIGN_LOST = 6;
   localparam int BIT_RETRY_FAIL = 5;
   localparam int BIT_PCS_ERR = 4;
   localparam int BIT_CHECKSUM = 3;
   localparam int BIT_FRAME_LOST = 2;
   localparam int BYTE1_LSB = 8;

   // Implemented flags; bits 11, 7 and 1:0 read as zero
   localparam logic [FLAG_W-1:0] FLAG_MASK = 12'h77c;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 12'h000;
   localparam logic [FLAG_W-1:0] ENABLE_RESET = 12'h000;

   // ==========================================================
   // Alignment retry limit
   localparam int RETRY_W = 4;
   localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
   localparam logic [RETRY_W-1:0] RETRY_ONE = 4'h1;
   localparam logic [RETRY_W-1:0] ALIGN_RETRY_MAX = 4'h3;

   // ==========================================================
   // Bus answers and states
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic [0:0] {
      RXES_WR_IDLE = 1'b0,
      RXES_WR_RESP = 1'b1
   } rxes_wr_e;

   typedef enum logic [0:0] {
      RXES_RD_IDLE = 1'b0,
      RXES_RD_DATA = 1'b1
   } rxes_rd_e;
endpackage

/* File: verilog/rxes_top.sv */
/*
 Receive error status bank: sticky write-one-to-clear fault flags
 gathered over all lanes, an interrupt enable register, a level
 interrupt, and the self-recovery requests for alignment and frame lock.
 Assumes the lane condition inputs come from receive logic on aclk and
 are high for each cycle in which the condition is seen.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns

// How it works
// R1: Each flag ORs its condition over lanes
// R2: Bit 10 set on skew beyond deskew
// R3: Bit 9 set on uncorrectable ECC error
// R4: Bit 8 set on corrected ECC error
// R5: Bit 6 set on lost lane alignment
// R6: Realign automatically; reset only if persisting
// R7: Bit 5 set when alignment retries exceed limit
// R8: Bit 4 set on sync, metaframe, CRC error
// R9: Bit 3 set on any lane CRC failure
// R10: Bit 2 set on loss of frame lock
// R11: Frame lock reacquired without any reset
// R12: Flags sticky until software writes one
// R13: Interrupt only when flag and enable set
// R14: Bit 7 reads zero; flags reset clear
module rxes_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [rxes_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [rxes_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [rxes_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rxes_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [rxes_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [rxes_pkg::LANES-1:0] lane_deskew_fail,
   input wire logic [rxes_pkg::LANES-1:0] lane_ecc_uncorrected,
   input wire logic [rxes_pkg::LANES-1:0] lane_ecc_corrected,
   input wire logic [rxes_pkg::LANES-1:0] lane_align_lost,
   input wire logic [rxes_pkg::LANES-1:0] lane_sync_err,
   input wire logic [rxes_pkg::LANES-1:0] lane_metaframe_err,
   input wire logic [rxes_pkg::LANES-1:0] lane_checksum_mismatch,
   input wire logic [rxes_pkg::LANES-1:0] lane_frame_lock_lost,
   input wire logic lanes_aligned,
   input wire logic frame_locked,
   output logic realign_req,
   output logic core_reset_req,
   output logic frame_relock_req,
   output logic irq
);

   // ==========================================================
   // Consolidation over lanes
   logic [rxes_pkg::FLAG_W-1:0] set_vec;
   logic any_align_lost;
   logic retry_exceeded;

   assign any_align_lost = |lane_align_lost; // R1

   always_comb begin
      set_vec = rxes_pkg::FLAGS_RESET;
      set_vec[rxes_pkg::BIT_DESKEW] = |lane_deskew_fail; // R2
      set_vec[rxes_pkg::BIT_ECC_FATAL] = |lane_ecc_uncorrected; // R3
      set_vec[rxes_pkg::BIT_ECC_CORR] = |lane_ecc_corrected; // R4
      set_vec[rxes_pkg::BIT_ALIGN_LOST] = any_align_lost; // R5
      set_vec[rxes_pkg::BIT_RETRY_FAIL] = retry_exceeded; // R7
      set_vec[rxes_pkg::BIT_PCS_ERR] = |lane_sync_err |
         |lane_metaframe_err | |lane_checksum_mismatch; // R8
      set_vec[rxes_pkg::BIT_CHECKSUM] = |lane_checksum_mismatch; // R9
      set_vec[rxes_pkg::BIT_FRAME_LOST] = |lane_frame_lock_lost; // R10
   end

   // ==========================================================
   // Recovery: alignment retries and frame relock
   logic [rxes_pkg::RETRY_W-1:0] retry_q;
   logic [rxes_pkg::RETRY_W-1:0] retry_d;
   logic realign_q;
   logic realign_d;
   logic core_reset_q;
   logic core_reset_d;
   logic relock_q;
   logic relock_d;

   // A loss past the limit means the misalignment is persisting
   assign retry_exceeded = any_align_lost &&
      (retry_q == rxes_pkg::ALIGN_RETRY_MAX); // R7

   always_comb begin
      retry_d = retry_q;
      core_reset_d = core_reset_q;
      // Each loss asks the MAC to realign on its own
      realign_d = any_align_lost; // R6
      if (any_align_lost) begin
         if (retry_q != rxes_pkg::ALIGN_RETRY_MAX) begin
            retry_d = retry_q + rxes_pkg::RETRY_ONE;
         end
      end else if (lanes_aligned) begin
         retry_d = rxes_pkg::RETRY_ZERO;
      end
      // Full reset only requested once retries are used up
      if (retry_exceeded) begin
         core_reset_d = 1'b1; // R6
      end else if (lanes_aligned && !any_align_lost) begin
         core_reset_d = 1'b0;
      end
      // Relock request holds until lock returns; no reset involved
      if (|lane_frame_lock_lost) begin
         relock_d = 1'b1; // R11
      end else if (frame_locked) begin
         relock_d = 1'b0; // R11
      end else begin
         relock_d = relock_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retry_q <= rxes_pkg::RETRY_ZERO;
         realign_q <= 1'b0;
         core_reset_q <= 1'b0;
         relock_q <= 1'b0;
      end else begin
         retry_q <= retry_d;
         realign_q <= realign_d;
         core_reset_q <= core_reset_d;
         relock_q <= relock_d;
      end
   end

   assign realign_req = realign_q;
   assign core_reset_req = core_reset_q;
   assign frame_relock_req = relock_q;

   // ==========================================================
   // Write channel
   rxes_pkg::rxes_wr_e wr_state_q;
   rxes_pkg::rxes_wr_e wr_state_d;
   logic aw_held_q;
   logic aw_held_d;
   logic w_held_q;
   logic w_held_d;
   logic [rxes_pkg::ADDR_W-1:0] aw_addr_q;
   logic [rxes_pkg::ADDR_W-1:0] aw_addr_d;
   logic [rxes_pkg::DATA_W-1:0] w_data_q;
   logic [rxes_pkg::DATA_W-1:0] w_data_d;
   logic [rxes_pkg::STRB_W-1:0] w_strb_q;
   logic [rxes_pkg::STRB_W-1:0] w_strb_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic wr_fire;
   logic [rxes_pkg::FLAG_W-1:0] lane_mask;
   logic [rxes_pkg::FLAG_W-1:0] wr_bits;

   assign s_axi_awready = (wr_state_q == rxes_pkg::RXES_WR_IDLE) &&
      !aw_held_q;
   assign s_axi_wready = (wr_state_q == rxes_pkg::RXES_WR_IDLE) &&
      !w_held_q;
   assign s_axi_bvalid = (wr_state_q == rxes_pkg::RXES_WR_RESP);
   assign s_axi_bresp = bresp_q;
   assign wr_fire = (wr_state_q == rxes_pkg::RXES_WR_IDLE) &&
      aw_held_q && w_held_q;

   // Only byte lanes 0 and 1 carry register bits
   assign lane_mask = {{(rxes_pkg::FLAG_W - rxes_pkg::BYTE1_LSB)
      {w_strb_q[1]}}, {rxes_pkg::BYTE1_LSB{w_strb_q[0]}}};
   assign wr_bits = w_data_q[rxes_pkg::FLAG_W-1:0] & lane_mask &
      rxes_pkg::FLAG_MASK; // R14

   always_comb begin
      wr_state_d = wr_state_q;
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bresp_d = bresp_q;
      case (wr_state_q)
         rxes_pkg::RXES_WR_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held_d = 1'b1;
               aw_addr_d = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held_d = 1'b1;
               w_data_d = s_axi_wdata;
               w_strb_d = s_axi_wstrb;
            end
            if (wr_fire) begin
               aw_held_d = 1'b0;
               w_held_d = 1'b0;
               wr_state_d = rxes_pkg::RXES_WR_RESP;
               if (aw_addr_q == rxes_pkg::ADDR_FLAGS ||
                   aw_addr_q == rxes_pkg::ADDR_ENABLE) begin
                  bresp_d = rxes_pkg::RESP_OKAY;
               end else begin
                  bresp_d = rxes_pkg::RESP_DECERR;
               end
            end
         end
         rxes_pkg::RXES_WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_d = rxes_pkg::RXES_WR_IDLE;
            end
         end
         default: begin
            wr_state_d = rxes_pkg::RXES_WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= rxes_pkg::RXES_WR_IDLE;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= rxes_pkg::DATA_ZERO;
         w_strb_q <= '0;
         bresp_q <= rxes_pkg::RESP_OKAY;
      end else begin
         wr_state_q <= wr_state_d;
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp_q <= bresp_d;
      end
   end

   // ==========================================================
   // Flags, enables and interrupt
   logic [rxes_pkg::FLAG_W-1:0] flags_q;
   logic [rxes_pkg::FLAG_W-1:0] flags_d;
   logic [rxes_pkg::FLAG_W-1:0] enable_q;
   logic [rxes_pkg::FLAG_W-1:0] enable_d;
   logic [rxes_pkg::FLAG_W-1:0] clr_vec;
   logic irq_q;
   logic irq_d;

   always_comb begin
      clr_vec = rxes_pkg::FLAGS_RESET;
      enable_d = enable_q;
      if (wr_fire && aw_addr_q == rxes_pkg::ADDR_FLAGS) begin
         clr_vec = wr_bits; // R12
      end
      if (wr_fire && aw_addr_q == rxes_pkg::ADDR_ENABLE) begin
         enable_d = (enable_q & ~(lane_mask & rxes_pkg::FLAG_MASK)) |
            wr_bits;
      end
      // A new event in the clearing cycle survives the clear
      flags_d = ((flags_q & ~clr_vec) | set_vec) &
         rxes_pkg::FLAG_MASK; // R12
      irq_d = |(flags_d & enable_d); // R13
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= rxes_pkg::FLAGS_RESET; // R14
         enable_q <= rxes_pkg::ENABLE_RESET;
         irq_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         enable_q <= enable_d;
         irq_q <= irq_d;
      end
   end

   assign irq = irq_q;

   // ==========================================================
   // Read channel
   rxes_pkg::rxes_rd_e rd_state_q;
   rxes_pkg::rxes_rd_e rd_state_d;
   logic [rxes_pkg::DATA_W-1:0] rdata_q;
   logic [rxes_pkg::DATA_W-1:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;

   assign s_axi_arready = (rd_state_q == rxes_pkg::RXES_RD_IDLE);
   assign s_axi_rvalid = (rd_state_q == rxes_pkg::RXES_RD_DATA);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_comb begin
      rd_state_d = rd_state_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      case (rd_state_q)
         rxes_pkg::RXES_RD_IDLE: begin
            if (s_axi_arvalid) begin
               rd_state_d = rxes_pkg::RXES_RD_DATA;
               rdata_d = rxes_pkg::DATA_ZERO;
               rresp_d = rxes_pkg::RESP_OKAY;
               if (s_axi_araddr == rxes_pkg::ADDR_FLAGS) begin
                  rdata_d[rxes_pkg::FLAG_W-1:0] = flags_q; // R14
               end else if (s_axi_araddr == rxes_pkg::ADDR_ENABLE) begin
                  rdata_d[rxes_pkg::FLAG_W-1:0] = enable_q;
               end else begin
                  rresp_d = rxes_pkg::RESP_DECERR;
               end
            end
         end
         rxes_pkg::RXES_RD_DATA: begin
            if (s_axi_rready) begin
               rd_state_d = rxes_pkg::RXES_RD_IDLE;
            end
         end
         default: begin
            rd_state_d = rxes_pkg::RXES_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= rxes_pkg::RXES_RD_IDLE;
         rdata_q <= rxes_pkg::DATA_ZERO;
         rresp_q <= rxes_pkg::RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

endmodule

/* File: sim/rxes_top_sva.sv */
/*
 Port checker for the receive error status bank.
 Assumes one clock domain and binding onto rxes_top.
*/
`timescale 1ns/1ns

// ==========================================
// Checker
module rxes_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [rxes_pkg::LANES-1:0] lane_align_lost,
   input wire logic [rxes_pkg::LANES-1:0] lane_frame_lock_lost,
   input wire logic lanes_aligned,
   input wire logic frame_locked,
   input wire logic realign_req,
   input wire logic core_reset_req,
   input wire logic frame_relock_req
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_relock_set: assert property (
      |lane_frame_lock_lost |=> frame_relock_req)
      else $error("relock request missing after frame lock loss");
   chk_relock_clear: assert property (
      frame_locked && !(|lane_frame_lock_lost) |=> !frame_relock_req)
      else $error("relock request kept after lock regained");
   chk_realign_pulse: assert property (
      |lane_align_lost |=> realign_req)
      else $error("realign request missing after alignment loss");
   chk_realign_quiet: assert property (
      !(|lane_align_lost) |=> !realign_req)
      else $error("realign request without alignment loss");
   chk_retry_fail: assert property (
      (|lane_align_lost && !lanes_aligned) [*4] |=> core_reset_req)
      else $error("core reset request missing after retries");
   chk_core_drop: assert property (
      lanes_aligned && !(|lane_align_lost) |=> !core_reset_req)
      else $error("core reset request kept after realignment");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after request");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   chk_aw_refused: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");

   cov_core_reset: cover property ($rose(core_reset_req));
   cov_relock: cover property ($rose(frame_relock_req));
   cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind rxes_top rxes_chk rxes_chk_inst (.*);

/* File: sim/testbench.sv */
/*
 Self-checking bench for the receive error status bank.
 Assumes rxes_pkg and rxes_top are compiled first.
*/
`timescale 1ns/1ns

// ==========================================
// Bench top
module testbench;
   localparam logic [11:0] F = rxes_pkg::ADDR_FLAGS;
   localparam logic [11:0] E = rxes_pkg::ADDR_ENABLE;
   localparam logic [1:0] OK = rxes_pkg::RESP_OKAY;
   localparam logic [1:0] DEC = rxes_pkg::RESP_DECERR;
   logic aclk, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [3:0] ln [8];
   logic aligned = 1'b1, locked = 1'b1;
   logic irq, rreq, creq, freq;
   logic [33:0] exp_r [$];
   logic [1:0] exp_b [$];
   logic [11:0] bits [8] = '{12'h400, 12'h200, 12'h100, 12'h040,
      12'h010, 12'h010, 12'h018, 12'h004};
   int fail_count = 0, total_checks = 0;

   rxes_top rxes_top_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lane_deskew_fail(ln[0]),
      .lane_ecc_uncorrected(ln[1]), .lane_ecc_corrected(ln[2]),
      .lane_align_lost(ln[3]), .lane_sync_err(ln[4]),
      .lane_metaframe_err(ln[5]), .lane_checksum_mismatch(ln[6]),
      .lane_frame_lock_lost(ln[7]), .lanes_aligned(aligned),
      .frame_locked(locked), .realign_req(rreq), .core_reset_req(creq),
      .frame_relock_req(freq), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic check(input string nm, input logic [33:0] e,
         input logic [33:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================
   // Response monitor
   // Ready and valid are read before the edge's updates land
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1)
         check("read", exp_r.pop_front(), {rresp, rdata});
      if (bvalid === 1'b1 && bready === 1'b1)
         check("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
   end

   // ==========================================
   // Bus master
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] r);
      int n;
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      // Let an edge pass so a following call never re-drives bready at once
      @(posedge aclk);
      if (n == 50) begin
         fail_count++;
         final_report();
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] r);
      int n;
      exp_r.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
      // Let an edge pass so a following call never re-drives rready at once
      @(posedge aclk);
      if (n == 50) begin
         fail_count++;
         final_report();
      end
   endtask

   task automatic pulse(input int k, input logic [3:0] m);
      ln[k] <= m;
      @(posedge aclk);
      ln[k] <= 4'h0;
      @(posedge aclk);
   endtask

   // ==========================================
   // Scenarios
   initial begin
      int k;
      logic [3:0] m;
      foreach (ln[i]) ln[i] = 4'h0;
      void'($urandom(32'hf1ac047d));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(F, 32'h0, OK);
      rd(E, 32'h0, OK);
      rd(12'h348, 32'h0, DEC);
      wr(12'h348, 32'hffff_ffff, DEC);
      // Event with enables off must stay silent
      pulse(0, 4'h8);
      check("irq masked", 1'b0, irq);
      wr(E, 32'hffff_ffff, OK);
      check("irq enabled", 1'b1, irq);
      rd(E, 32'h77c, OK);
      wr(F, 32'h400, OK);
      check("irq cleared", 1'b0, irq);
      for (k = 0; k < 8; k++) begin
         m = 4'h0;
         while (m == 4'h0) m = 4'($urandom);
         pulse(k, m);
         check("irq event", 1'b1, irq);
         wr(F, 32'h0, OK);
         rd(F, {20'h0, bits[k]}, OK);
         wr(F, {20'h0, bits[k]} | 32'h80, OK);
         rd(F, 32'h0, OK);
      end
      // Three losses bring the retry count up to the limit without exceeding it
      aligned <= 1'b0;
      ln[3] <= 4'h4;
      repeat (3) @(posedge aclk);
      ln[3] <= 4'h0;
      @(posedge aclk);
      rd(F, 32'h40, OK);
      ln[3] <= 4'h1;
      repeat (4) @(posedge aclk);
      ln[3] <= 4'h0;
      @(posedge aclk);
      rd(F, 32'h60, OK);
      check("core reset", 1'b1, creq);
      aligned <= 1'b1;
      repeat (2) @(posedge aclk);
      check("core reset", 1'b0, creq);
      wr(F, 32'hfff, OK);
      rd(F, 32'h0, OK);
      final_report();
   end
endmodule
